// file: cic_pkg.sv
package cic_pkg;
    localparam int ORDER_DEFAULT = 3;
    localparam int DIFF_DELAY_DEFAULT = 1;
    localparam int DIFF_DELAY_MAX = 2;
    localparam int RATIO_MAX = 256;
    localparam int RATIO_LOG2_MAX = 8;
    localparam int ACC_WIDTH_DEFAULT = ORDER_DEFAULT * RATIO_LOG2_MAX + 1;
    localparam int SETTLE_PERIODS = 3;
    localparam real MOD_CLOCK_MHZ = 8.192;
    localparam real SAMPLE_RATE_KHZ = 32.0;
    localparam int SYS_CLOCK_MHZ = 100;
    // ratio select codes
    typedef enum logic [1:0] {
        RATIO_64 = 2'h0,
        RATIO_128 = 2'h1,
        RATIO_256 = 2'h2
    } ratio_sel_type;
    localparam logic [8:0] RATIO_64_COUNT = 9'h040;
    localparam logic [8:0] RATIO_128_COUNT = 9'h080;
    localparam logic [8:0] RATIO_256_COUNT = 9'h100;
    localparam logic [1:0] SYNC_DEPTH = 2'h3;
endpackage : cic_pkg

// file: cic_stream_if.sv
`timescale 1ns/1ps
interface cic_stream_if #(parameter int WIDTH = 25);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : cic_stream_if

// file: skid_buffer.sv
`timescale 1ns/1ps
module skid_buffer #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    cic_stream_if.sink in_s,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [1:0] count;
    logic rd_ptr;
    logic wr_ptr;
    wire push = in_s.valid && in_s.ready;
    wire pop = out_valid_o && out_ready_i;
    assign in_s.ready = (count != 2'(DEPTH));
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // cleared so the data output reads zero after any reset
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            count <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else if (ce_i) begin
            if (push) begin
                mem[wr_ptr] <= in_s.data;
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + 2'(push) - 2'(pop);
        end
    end

    AST_NO_OVERFLOW: assert property (@(posedge clk_i) disable iff (rst_i)
        count <= 2'(DEPTH)) else $error("buffer count overflow");
endmodule : skid_buffer

// file: sinc3_cic_decimator.sv
`timescale 1ns/1ps
// Notes on behaviour
// - n integrators at modulator rate, then n combs at rate divided by ratio
// - only every ratio-th integrator output reaches the comb section
// - each integrator adds its input to its previous output per input bit
// - each comb subtracts its input from m decimated samples ago
// - default is third order with differential delay one
// - one output word per ratio modulator clocks
// - step response settles within three output periods
// - ratio selectable as 64, 128 or 256
// - system runs 8.192 MHz modulator clock, 32 kHz output rate at ratio 256
module sinc3_cic_decimator
    import cic_pkg::*;
#(
    parameter int ORDER = ORDER_DEFAULT,
    parameter int DIFF_DELAY = DIFF_DELAY_DEFAULT,
    parameter int WIDTH = ACC_WIDTH_DEFAULT
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic MODULATOR_CLOCK_IN_I,
    input wire logic MOD_DATA_I,
    input wire logic [1:0] DECIMATION_RATIO_I,
    output logic [WIDTH-1:0] SAMPLE_DATA_O,
    output logic SAMPLE_VALID_O,
    output logic SAMPLE_STROBE_O,
    input wire logic SAMPLE_READY_I,
    output logic OVERRUN_O
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COMB = 3'b010,
        ST_PUSH = 3'b100
    } state_type;

    // modulator clock and data are asynchronous; three stages each
    logic [2:0] clk_sync;
    logic [2:0] dat_sync;
    logic clk_level;
    logic [8:0] ratio_count;
    logic [8:0] ratio_len;
    logic [WIDTH-1:0] integ [ORDER+1];
    logic [WIDTH-1:0] comb [ORDER+1];
    logic [WIDTH-1:0] comb_out;
    logic [WIDTH-1:0] decim;
    state_type state;
    state_type next_state;
    logic strobe;
    logic overrun;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            clk_sync <= 3'h0;
            dat_sync <= 3'h0;
            clk_level <= 1'b0;
        end else if (CE_I) begin
            clk_sync <= {clk_sync[1:0], MODULATOR_CLOCK_IN_I};
            dat_sync <= {dat_sync[1:0], MOD_DATA_I};
            if (clk_sync[1] == clk_sync[2]) begin
                clk_level <= clk_sync[2];
            end
        end
    end

    // rising edge of the agreed clock; data stable since falling edge
    wire clk_agree = (clk_sync[1] == clk_sync[2]);
    wire mod_tick = CE_I && clk_agree && clk_sync[2] && !clk_level;
    // data passes as many stages as clock and changes on the falling edge, so it is sampled mid-bit
    wire mod_bit = dat_sync[2];
    wire [WIDTH-1:0] in_value = mod_bit ? WIDTH'(1) : {WIDTH{1'b1}};

    assign ratio_len = (DECIMATION_RATIO_I == RATIO_64) ? RATIO_64_COUNT :
                       (DECIMATION_RATIO_I == RATIO_128) ? RATIO_128_COUNT :
                       RATIO_256_COUNT;
    wire ratio_end = (ratio_count == ratio_len - 9'h001);
    wire decim_tick = mod_tick && ratio_end;

    assign integ[0] = in_value;
    genvar g;
    generate
        for (g = 0; g < ORDER; g++) begin : g_integ
            logic [WIDTH-1:0] acc;
            always_ff @(posedge SYS_CLK_I) begin
                if (RST_I) begin
                    acc <= '0;
                end else if (mod_tick) begin
                    acc <= acc + integ[g];
                end
            end
            assign integ[g+1] = acc;
        end
    endgenerate

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ratio_count <= 9'h000;
            decim <= '0;
        end else if (mod_tick) begin
            ratio_count <= ratio_end ? 9'h000 : ratio_count + 9'h001;
            if (ratio_end) begin
                decim <= integ[ORDER];
            end
        end
    end

    // combs move only in the one slow-rate comb cycle
    wire comb_update = (state == ST_COMB) && CE_I;
    assign comb[0] = decim;
    generate
        for (g = 0; g < ORDER; g++) begin : g_comb
            logic [WIDTH-1:0] hist [DIFF_DELAY];
            // unpipelined chain: a pipeline would stretch the settling time
            assign comb[g+1] = comb[g] - hist[DIFF_DELAY-1];
            always_ff @(posedge SYS_CLK_I) begin
                if (RST_I) begin
                    for (int k = 0; k < DIFF_DELAY; k++) begin
                        hist[k] <= '0;
                    end
                end else if (comb_update) begin
                    hist[0] <= comb[g];
                    for (int k = 1; k < DIFF_DELAY; k++) begin
                        hist[k] <= hist[k-1];
                    end
                end
            end
        end
    endgenerate

    // registered so the buffer sees a flop, not the subtractor chain
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            comb_out <= '0;
        end else if (comb_update) begin
            comb_out <= comb[ORDER];
        end
    end

    cic_stream_if #(.WIDTH(WIDTH)) word_s ();

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: if (decim_tick) next_state = ST_COMB;
            ST_COMB: next_state = ST_PUSH;
            ST_PUSH: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    assign word_s.valid = (state == ST_PUSH) && CE_I;
    assign word_s.data = comb_out;

    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state <= ST_IDLE;
            strobe <= 1'b0;
            overrun <= 1'b0;
        end else if (CE_I) begin
            state <= next_state;
            strobe <= word_s.valid && word_s.ready;
            // sticky: a full buffer drops the word, reported here
            if (word_s.valid && !word_s.ready) begin
                overrun <= 1'b1;
            end
        end
    end

    skid_buffer #(.WIDTH(WIDTH), .DEPTH(2)) u_buf (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .ce_i(CE_I),
        .in_s(word_s),
        .out_valid_o(SAMPLE_VALID_O),
        .out_data_o(SAMPLE_DATA_O),
        .out_ready_i(SAMPLE_READY_I)
    );

    assign SAMPLE_STROBE_O = strobe;
    assign OVERRUN_O = overrun;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    AST_DECIM_TO_COMB: assert property (decim_tick |=> state == ST_COMB)
        else $error("comb not started after decimation");
    AST_COMB_TO_PUSH: assert property (comb_update |=> state == ST_PUSH)
        else $error("push did not follow comb");
    AST_STROBE_PULSE: assert property (strobe |=> !strobe)
        else $error("strobe longer than one cycle");
    AST_COUNT_RANGE: assert property (ratio_count < ratio_len)
        else $error("ratio counter out of range");
    AST_INTEG_STEP: assert property (mod_tick |=>
        g_integ[0].acc == $past(g_integ[0].acc) + $past(in_value))
        else $error("first integrator did not accumulate");
    AST_INTEG_HOLD: assert property (!mod_tick |=> $stable(g_integ[0].acc))
        else $error("integrator moved without a tick");
    AST_COMB_DIFF: assert property (comb_update |=>
        g_comb[0].hist[0] == $past(decim))
        else $error("comb history did not take the word");
    AST_DECIM_LOAD: assert property (decim_tick |=>
        decim == $past(integ[ORDER]))
        else $error("decimated word not captured");
    AST_STROBE_CAUSE: assert property (strobe |-> $past(word_s.valid))
        else $error("strobe without a word");

    COV_DECIM: cover property (decim_tick);
    COV_WORD_OUT: cover property (SAMPLE_VALID_O && SAMPLE_READY_I);
    COV_BUF_FULL: cover property (!word_s.ready);
    COV_OVERRUN: cover property (overrun);
endmodule : sinc3_cic_decimator

// file: mod_stream_model.sv
`timescale 1ns/1ps
module mod_stream_model #(
    parameter int HALF = 5
) (
    input wire logic clk_i,
    input wire logic [1:0] pattern_i,
    output logic mod_clk_o,
    output logic mod_data_o
);
    // pattern 0 all zeros, 1 all ones, 2 alternating
    int cnt = 0;
    initial begin
        mod_clk_o = 1'b0;
        mod_data_o = 1'b0;
    end
    // moves on the system falling edge, clear of the sampling edge
    always @(negedge clk_i) begin
        cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
        mod_clk_o <= (cnt < HALF);
        if (cnt == HALF) begin
            case (pattern_i)
                2'h0: mod_data_o <= 1'b0;
                2'h1: mod_data_o <= 1'b1;
                default: mod_data_o <= ~mod_data_o;
            endcase
        end
    end
endmodule : mod_stream_model

// file: sinc3_cic_decimator_tb.sv
`timescale 1ns/1ps
module sinc3_cic_decimator_tb;
    import cic_pkg::*;
    typedef logic [ACC_WIDTH_DEFAULT-1:0] word_type;
    localparam int MOD_PERIOD = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic ready = 1'b1;
    logic [1:0] ratio = 2'h0;
    logic [1:0] pattern = 2'h0;
    logic mod_clk;
    logic mod_data;
    logic strobe;
    logic valid;
    logic overrun;
    word_type data;
    int bad_count = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    mod_stream_model #(.HALF(MOD_PERIOD / 2)) partner (.clk_i(clk),
        .pattern_i(pattern), .mod_clk_o(mod_clk), .mod_data_o(mod_data));
    sinc3_cic_decimator dut (.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce),
        .MODULATOR_CLOCK_IN_I(mod_clk), .MOD_DATA_I(mod_data),
        .DECIMATION_RATIO_I(ratio), .SAMPLE_DATA_O(data),
        .SAMPLE_VALID_O(valid), .SAMPLE_STROBE_O(strobe),
        .SAMPLE_READY_I(ready), .OVERRUN_O(overrun));

    function automatic word_type cube(input int r, input bit neg);
        int v;
        v = r * r * r;
        return neg ? word_type'(-v) : word_type'(v);
    endfunction : cube

    task automatic check(input string name, input word_type seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    task automatic do_reset(input logic [1:0] code);
        @(negedge clk);
        rst = 1'b1;
        ratio = code;
        ready = 1'b1;
        repeat (8) @(negedge clk);
        check("valid in reset", word_type'(valid), '0);
        check("overrun in reset", word_type'(overrun), '0);
        check("data in reset", data, '0);
        rst = 1'b0;
    endtask : do_reset

    // bounded wait so a silent filter cannot hang the run
    task automatic get_word(output word_type w, output time t);
        int n;
        @(negedge clk);
        for (n = 0; n < 3000 && strobe !== 1'b1; n++) @(negedge clk);
        check("strobe", word_type'(strobe), word_type'(1'b1));
        w = data;
        t = $time;
    endtask : get_word

    task automatic skip_words(input int n);
        word_type w;
        time t;
        repeat (n) get_word(w, t);
    endtask : skip_words

    task automatic test_ratio(input logic [1:0] code, input bit neg);
        word_type w;
        time t0;
        time t1;
        int r;
        // code 3 is decoded as the largest ratio
        r = (code == RATIO_64) ? int'(RATIO_64_COUNT) :
            (code == RATIO_128) ? int'(RATIO_128_COUNT) :
            int'(RATIO_256_COUNT);
        do_reset(code);
        pattern = neg ? 2'h0 : 2'h1;
        // the sum spans three periods, so the fourth word is settled
        skip_words(SETTLE_PERIODS);
        get_word(w, t0);
        get_word(w, t1);
        check("dc gain", w, cube(r, neg));
        check("word spacing", word_type'(t1 - t0),
            word_type'(r * MOD_PERIOD * 10));
        @(negedge clk);
        check("strobe width", word_type'(strobe), '0);
    endtask : test_ratio

    task automatic test_overrun();
        word_type w;
        time t;
        do_reset(2'h0);
        pattern = 2'h1;
        skip_words(8);
        @(negedge clk);
        ready = 1'b0;
        get_word(w, t);
        check("first held", w, cube(64, 1'b0));
        get_word(w, t);
        check("no early overrun", word_type'(overrun), '0);
        repeat (700) @(negedge clk);
        check("overrun", word_type'(overrun), word_type'(1'b1));
        check("valid held", word_type'(valid), word_type'(1'b1));
        check("data held", data, cube(64, 1'b0));
        // a low clock enable must hold the buffer even with ready high
        ce = 1'b0;
        ready = 1'b1;
        repeat (2) @(negedge clk);
        check("frozen valid", word_type'(valid), word_type'(1'b1));
        check("frozen data", data, cube(64, 1'b0));
        ce = 1'b1;
        @(negedge clk);
        check("second word", word_type'(valid), word_type'(1'b1));
        check("second data", data, cube(64, 1'b0));
        @(negedge clk);
        check("drained", word_type'(valid), '0);
        check("overrun sticky", word_type'(overrun), word_type'(1'b1));
    endtask : test_overrun

    task automatic test_step();
        word_type w;
        time t;
        do_reset(2'h0);
        pattern = 2'h2;
        skip_words(8);
        get_word(w, t);
        check("zero input", w, '0);
        pattern = 2'h1;
        // the step lands early in the next period; three more finish it
        skip_words(SETTLE_PERIODS);
        get_word(w, t);
        check("step settled", w, cube(64, 1'b0));
    endtask : test_step

    initial begin
        test_ratio(2'h0, 1'b0);
        test_ratio(2'h1, 1'b1);
        test_ratio(2'h2, 1'b0);
        test_ratio(2'h3, 1'b1);
        test_overrun();
        test_step();
        finish_test();
    end

    // about twice the expected run length
    initial begin
        #1000000;
        bad_count++;
        finish_test();
    end
endmodule : sinc3_cic_decimator_tb
